//--- src/tpg_pkg.sv
package tpg_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int          ADDR_W    = 8;
   localparam int          DATA_W    = 8;
   localparam int          FIRST_W   = 8;
   localparam int          SECOND_W  = 7;

   // ----------------------------------------------------------------
   // data memory offsets
   // ----------------------------------------------------------------
   localparam logic [7:0]  OFS_FIRST_LEVEL      = 8'h00;
   localparam logic [7:0]  OFS_FIRST_DIRECTION  = 8'h01;
   localparam logic [7:0]  OFS_FIRST_PULLUP     = 8'h02;
   localparam logic [7:0]  OFS_FIRST_WAKE       = 8'h03;
   localparam logic [7:0]  OFS_SECOND_LEVEL     = 8'h04;
   localparam logic [7:0]  OFS_SECOND_DIRECTION = 8'h05;
   localparam logic [7:0]  OFS_SECOND_PULLUP    = 8'h06;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_FIRST_LEVEL      = 8'hFF;
   localparam logic [7:0]  RST_FIRST_DIRECTION  = 8'hFF;
   localparam logic [7:0]  RST_FIRST_PULLUP     = 8'h00;
   localparam logic [7:0]  RST_FIRST_WAKE       = 8'h00;
   localparam logic [6:0]  RST_SECOND_LEVEL     = 7'h7F;
   localparam logic [6:0]  RST_SECOND_DIRECTION = 7'h7F;
   localparam logic [6:0]  RST_SECOND_PULLUP    = 7'h00;

endpackage : tpg_pkg

//--- src/tpg_wake.sv
`timescale 1ns/1ps

module tpg_wake (
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic                          ce,
   input  wire logic [tpg_pkg::FIRST_W-1:0]   pins,
   input  wire logic [tpg_pkg::FIRST_W-1:0]   enable,
   input  wire logic                          sleep,
   output logic                               wake
);

   logic [tpg_pkg::FIRST_W-1:0] meta_r;
   logic [tpg_pkg::FIRST_W-1:0] meta_nxt;
   logic [tpg_pkg::FIRST_W-1:0] sync_r;
   logic [tpg_pkg::FIRST_W-1:0] sync_nxt;
   logic [tpg_pkg::FIRST_W-1:0] prev_r;
   logic [tpg_pkg::FIRST_W-1:0] prev_nxt;
   logic [tpg_pkg::FIRST_W-1:0] fall;
   logic                        wake_r;
   logic                        wake_nxt;

   // ----------------------------------------------------------------
   // per pin falling edge on the synchronised level
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < tpg_pkg::FIRST_W; g++) begin : g_pin
         assign fall[g] = prev_r[g] & ~sync_r[g] & enable[g];   // see [RQ9] see [RQ13]
      end
   endgenerate

   always_comb begin
      meta_nxt = pins;
      sync_nxt = meta_r;
      prev_nxt = sync_r;
      // only a sleeping core is woken; any enabled pin gives one pulse
      wake_nxt = sleep & (|fall);   // see [RQ8] see [RQ14]
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // idle high, so a pin held low at release shows one falling edge once its low level reaches sync_r
         meta_r <= 8'hFF;
         sync_r <= 8'hFF;
         prev_r <= 8'hFF;
         wake_r <= 1'b0;
      end else if (ce) begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         prev_r <= prev_nxt;
         wake_r <= wake_nxt;
      end
   end

   assign wake = wake_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_wake_needs_sleep: assert property (   // see [RQ10]
      @(posedge clk) disable iff (!rst_n)
      (ce && !sleep) |=> !wake)
      else $error("wake pulse while core awake");

   a_wake_on_fall: assert property (   // see [RQ8]
      @(posedge clk) disable iff (!rst_n)
      (ce && sleep && |(prev_r & ~sync_r & enable)) |=> wake)
      else $error("enabled falling edge gave no wake pulse");

   a_wake_disabled: assert property (   // see [RQ13]
      @(posedge clk) disable iff (!rst_n)
      (ce && enable == 8'h00) |=> !wake)
      else $error("wake pulse with all pins disabled");

endmodule : tpg_wake

//--- src/tpg_top.sv
// Behaviour
// [RQ1] a port read returns the pin level sampled at the read edge, with no input latch.
// [RQ2] written output data stays in its latch until that port's level register is written again.
// [RQ3] unimplemented bits, bit 7 of every second-port register among them, read as zero.
// [RQ4] software clears the direction bit of unbonded pins after power-on and leaves their pull-up and wake bits.
// [RQ5] every pin used as digital input can switch on a weak pull-up from its own pull-up bit.
// [RQ6] the pull-up acts only when the shared function is digital input or open-drain output.
// [RQ7] pull-up bits disable at 0, enable at 1, and reset to 0.
// [RQ8] in sleep or idle a falling edge on an enabled first-port pin requests wake-up.
// [RQ9] each first-port pin has its own wake enable bit.
// [RQ10] a wake enable works only on a general purpose input pin while the core sleeps or idles.
// [RQ11] software may change any pin's direction at any time.
// [RQ12] direction 1 makes the pin a readable input, 0 a CMOS output driven from its latch.
// [RQ13] wake enable bits disable wake-up at 0 and enable it at 1.
// [RQ14] first-port inputs are synchronised and any enabled falling edge gives one wake pulse.
// [RQ15] a read of an output pin returns its data latch.
`timescale 1ns/1ps

module tpg_top (
   input  wire logic                           MCLK,
   input  wire logic                           RESET_N,
   input  wire logic                           CE,
   input  wire logic [tpg_pkg::ADDR_W-1:0]     MEM_ADDR,
   input  wire logic                           MEM_WR,
   input  wire logic                           MEM_RD,
   input  wire logic [tpg_pkg::DATA_W-1:0]     MEM_WDATA,
   output logic      [tpg_pkg::DATA_W-1:0]     MEM_RDATA,
   input  wire logic [tpg_pkg::FIRST_W-1:0]    PA_IN,
   output logic      [tpg_pkg::FIRST_W-1:0]    PA_OUT,
   output logic      [tpg_pkg::FIRST_W-1:0]    PA_OE,
   output logic      [tpg_pkg::FIRST_W-1:0]    PA_PULLUP,
   input  wire logic [tpg_pkg::FIRST_W-1:0]    PA_PU_ALLOW,
   input  wire logic [tpg_pkg::FIRST_W-1:0]    PA_GPIO_SEL,
   input  wire logic [tpg_pkg::SECOND_W-1:0]   PB_IN,
   output logic      [tpg_pkg::SECOND_W-1:0]   PB_OUT,
   output logic      [tpg_pkg::SECOND_W-1:0]   PB_OE,
   output logic      [tpg_pkg::SECOND_W-1:0]   PB_PULLUP,
   input  wire logic [tpg_pkg::SECOND_W-1:0]   PB_PU_ALLOW,
   input  wire logic                           CORE_SLEEP,
   output logic                                WAKE_REQ
);

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [7:0] first_port_level_r;
   logic [7:0] first_port_level_nxt;
   logic [7:0] first_port_direction_r;
   logic [7:0] first_port_direction_nxt;
   logic [7:0] first_port_pullup_enable_r;
   logic [7:0] first_port_pullup_enable_nxt;
   logic [7:0] first_port_wake_enable_r;
   logic [7:0] first_port_wake_enable_nxt;
   logic [6:0] second_port_level_r;
   logic [6:0] second_port_level_nxt;
   logic [6:0] second_port_direction_r;
   logic [6:0] second_port_direction_nxt;
   logic [6:0] second_port_pullup_enable_r;
   logic [6:0] second_port_pullup_enable_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [7:0] pa_oe_r;
   logic [7:0] pa_oe_nxt;
   logic [7:0] pa_pu_r;
   logic [7:0] pa_pu_nxt;
   logic [6:0] pb_oe_r;
   logic [6:0] pb_oe_nxt;
   logic [6:0] pb_pu_r;
   logic [6:0] pb_pu_nxt;
   logic [7:0] wake_en;
   logic [7:0] read_mux;
   logic       wr_cyc;

   assign wr_cyc = MEM_WR;

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always_comb begin
      first_port_level_nxt          = first_port_level_r;
      first_port_direction_nxt      = first_port_direction_r;
      first_port_pullup_enable_nxt  = first_port_pullup_enable_r;
      first_port_wake_enable_nxt    = first_port_wake_enable_r;
      second_port_level_nxt         = second_port_level_r;
      second_port_direction_nxt     = second_port_direction_r;
      second_port_pullup_enable_nxt = second_port_pullup_enable_r;
      if (wr_cyc) begin
         unique case (MEM_ADDR)
            tpg_pkg::OFS_FIRST_LEVEL: begin
               first_port_level_nxt = MEM_WDATA;   // see [RQ2]
            end
            tpg_pkg::OFS_FIRST_DIRECTION: begin
               first_port_direction_nxt = MEM_WDATA;   // see [RQ11]
            end
            tpg_pkg::OFS_FIRST_PULLUP: begin
               first_port_pullup_enable_nxt = MEM_WDATA;   // see [RQ7]
            end
            tpg_pkg::OFS_FIRST_WAKE: begin
               first_port_wake_enable_nxt = MEM_WDATA;   // see [RQ9]
            end
            tpg_pkg::OFS_SECOND_LEVEL: begin
               second_port_level_nxt = MEM_WDATA[6:0];   // see [RQ2]
            end
            tpg_pkg::OFS_SECOND_DIRECTION: begin
               second_port_direction_nxt = MEM_WDATA[6:0];   // see [RQ11]
            end
            tpg_pkg::OFS_SECOND_PULLUP: begin
               second_port_pullup_enable_nxt = MEM_WDATA[6:0];   // see [RQ7]
            end
            default: begin
               // other data memory addresses belong to other blocks
            end
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         first_port_level_r          <= tpg_pkg::RST_FIRST_LEVEL;
         first_port_direction_r      <= tpg_pkg::RST_FIRST_DIRECTION;
         first_port_pullup_enable_r  <= tpg_pkg::RST_FIRST_PULLUP;   // see [RQ7]
         first_port_wake_enable_r    <= tpg_pkg::RST_FIRST_WAKE;
         second_port_level_r         <= tpg_pkg::RST_SECOND_LEVEL;
         second_port_direction_r     <= tpg_pkg::RST_SECOND_DIRECTION;
         second_port_pullup_enable_r <= tpg_pkg::RST_SECOND_PULLUP;   // see [RQ7]
      end else if (CE) begin
         first_port_level_r          <= first_port_level_nxt;
         first_port_direction_r      <= first_port_direction_nxt;
         first_port_pullup_enable_r  <= first_port_pullup_enable_nxt;
         first_port_wake_enable_r    <= first_port_wake_enable_nxt;
         second_port_level_r         <= second_port_level_nxt;
         second_port_direction_r     <= second_port_direction_nxt;
         second_port_pullup_enable_r <= second_port_pullup_enable_nxt;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // pins are sampled raw in the read cycle; no input latch, so the
   // level must be settled at that edge
   always_comb begin
      read_mux = 8'h00;   // see [RQ3]
      unique case (MEM_ADDR)
         tpg_pkg::OFS_FIRST_LEVEL: begin
            read_mux = (first_port_direction_r & PA_IN)
                     | (~first_port_direction_r & first_port_level_r);   // see [RQ1] see [RQ15]
         end
         tpg_pkg::OFS_FIRST_DIRECTION: begin
            read_mux = first_port_direction_r;
         end
         tpg_pkg::OFS_FIRST_PULLUP: begin
            read_mux = first_port_pullup_enable_r;
         end
         tpg_pkg::OFS_FIRST_WAKE: begin
            read_mux = first_port_wake_enable_r;
         end
         tpg_pkg::OFS_SECOND_LEVEL: begin
            read_mux = {1'b0, (second_port_direction_r & PB_IN)
                     | (~second_port_direction_r & second_port_level_r)};   // see [RQ1] see [RQ3]
         end
         tpg_pkg::OFS_SECOND_DIRECTION: begin
            read_mux = {1'b0, second_port_direction_r};   // see [RQ3]
         end
         tpg_pkg::OFS_SECOND_PULLUP: begin
            read_mux = {1'b0, second_port_pullup_enable_r};   // see [RQ3]
         end
         default: begin
            read_mux = 8'h00;
         end
      endcase
      rdata_nxt = MEM_RD ? read_mux : rdata_r;
   end

   // ----------------------------------------------------------------
   // pin drive and pull-ups
   // ----------------------------------------------------------------
   // registered so every pin control leaves from a flop; costs one
   // cycle of latency after a register write
   always_comb begin
      pa_oe_nxt = ~first_port_direction_r;   // see [RQ12]
      pb_oe_nxt = ~second_port_direction_r;   // see [RQ12]
      pa_pu_nxt = first_port_pullup_enable_r & PA_PU_ALLOW;   // see [RQ5] see [RQ6]
      pb_pu_nxt = second_port_pullup_enable_r & PB_PU_ALLOW;   // see [RQ5] see [RQ6]
   end

   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         rdata_r <= 8'h00;
         pa_oe_r <= 8'h00;
         pb_oe_r <= 7'h00;
         pa_pu_r <= 8'h00;
         pb_pu_r <= 7'h00;
      end else if (CE) begin
         rdata_r <= rdata_nxt;
         pa_oe_r <= pa_oe_nxt;
         pb_oe_r <= pb_oe_nxt;
         pa_pu_r <= pa_pu_nxt;
         pb_pu_r <= pb_pu_nxt;
      end
   end

   assign MEM_RDATA = rdata_r;
   assign PA_OUT    = first_port_level_r;
   assign PB_OUT    = second_port_level_r;
   assign PA_OE     = pa_oe_r;
   assign PB_OE     = pb_oe_r;
   assign PA_PULLUP = pa_pu_r;
   assign PB_PULLUP = pb_pu_r;

   // ----------------------------------------------------------------
   // wake-up
   // ----------------------------------------------------------------
   // enable counts only for a general purpose input pin
   assign wake_en = first_port_wake_enable_r & first_port_direction_r & PA_GPIO_SEL;   // see [RQ10]

   tpg_wake u_wake (
      .clk    (MCLK),
      .rst_n  (RESET_N),
      .ce     (CE),
      .pins   (PA_IN),
      .enable (wake_en),
      .sleep  (CORE_SLEEP),   // see [RQ10]
      .wake   (WAKE_REQ)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_read_pin_raw: assert property (   // see [RQ1]
      @(posedge MCLK) disable iff (!RESET_N)
      (CE && MEM_RD && MEM_ADDR == tpg_pkg::OFS_FIRST_LEVEL && first_port_direction_r == 8'hFF)
      |=> MEM_RDATA == $past(PA_IN))
      else $error("input pin read not taken from the pin");

   a_read_out_latch: assert property (   // see [RQ15]
      @(posedge MCLK) disable iff (!RESET_N)
      (CE && MEM_RD && MEM_ADDR == tpg_pkg::OFS_FIRST_LEVEL && first_port_direction_r == 8'h00)
      |=> MEM_RDATA == $past(first_port_level_r))
      else $error("output pin read not taken from the latch");

   a_latch_hold: assert property (   // see [RQ2]
      @(posedge MCLK) disable iff (!RESET_N)
      !(MEM_WR && MEM_ADDR == tpg_pkg::OFS_FIRST_LEVEL) |=> $stable(PA_OUT))
      else $error("output latch changed without a write");

   a_second_bit7: assert property (   // see [RQ3]
      @(posedge MCLK) disable iff (!RESET_N)
      (CE && MEM_RD && MEM_ADDR >= tpg_pkg::OFS_SECOND_LEVEL) |=> MEM_RDATA[7] == 1'b0)
      else $error("unimplemented bit read as one");

   a_pullup_gate: assert property (   // see [RQ6]
      @(posedge MCLK) disable iff (!RESET_N)
      CE |=> (PA_PULLUP == $past(first_port_pullup_enable_r & PA_PU_ALLOW))
          && (PB_PULLUP == $past(second_port_pullup_enable_r & PB_PU_ALLOW)))
      else $error("pull-up not gated by its bit and function");

   a_pullup_reset: assert property (   // see [RQ7]
      @(posedge MCLK)
      !RESET_N |=> (PA_PULLUP == 8'h00 && PB_PULLUP == 7'h00 && PA_OE == 8'h00))
      else $error("pull-up or drive active after reset");

   a_dir_write: assert property (   // see [RQ11]
      @(posedge MCLK) disable iff (!RESET_N)
      (CE && MEM_WR && MEM_ADDR == tpg_pkg::OFS_FIRST_DIRECTION) ##1 CE
      |=> PA_OE == ~$past(MEM_WDATA, 2))
      else $error("direction write did not reach the drivers in two cycles");

   a_dir_drive: assert property (   // see [RQ12]
      @(posedge MCLK) disable iff (!RESET_N)
      CE |=> PB_OE == ~$past(second_port_direction_r))
      else $error("second port drive does not follow direction");

   a_first_drive: assert property (   // see [RQ12]
      @(posedge MCLK) disable iff (!RESET_N)
      CE |=> PA_OE == ~$past(first_port_direction_r))
      else $error("first port drive does not follow direction");

   a_second_hold: assert property (   // see [RQ2]
      @(posedge MCLK) disable iff (!RESET_N)
      !(MEM_WR && MEM_ADDR == tpg_pkg::OFS_SECOND_LEVEL) |=> $stable(PB_OUT))
      else $error("second output latch changed without a write");

   a_unmapped_zero: assert property (   // see [RQ3]
      @(posedge MCLK) disable iff (!RESET_N)
      (CE && MEM_RD && MEM_ADDR > tpg_pkg::OFS_SECOND_PULLUP) |=> MEM_RDATA == 8'h00)
      else $error("unmapped address read as nonzero");

   a_second_read_raw: assert property (   // see [RQ1]
      @(posedge MCLK) disable iff (!RESET_N)
      (CE && MEM_RD && MEM_ADDR == tpg_pkg::OFS_SECOND_LEVEL
         && second_port_direction_r == 7'h7F)
      |=> MEM_RDATA == {1'b0, $past(PB_IN)})
      else $error("second port input read not taken from the pin");

   a_wake_gpio_only: assert property (   // see [RQ10]
      @(posedge MCLK) disable iff (!RESET_N)
      (CE && (first_port_wake_enable_r & first_port_direction_r & PA_GPIO_SEL) == 8'h00)
      |=> !WAKE_REQ)
      else $error("wake pulse from a pin that is not a general purpose input");

endmodule : tpg_top

//--- dv/tpg_pins.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// board side of both ports: switches, weak pull-ups, open pins
// ----------------------------------------------------------------
module tpg_pins (
   input  wire logic       clk,
   input  wire logic [7:0] pa_out,
   input  wire logic [7:0] pa_oe,
   input  wire logic [7:0] pa_pullup,
   input  wire logic [7:0] pa_ext,
   input  wire logic [7:0] pa_ext_en,
   input  wire logic [6:0] pb_out,
   input  wire logic [6:0] pb_oe,
   input  wire logic [6:0] pb_pullup,
   input  wire logic [6:0] pb_ext,
   input  wire logic [6:0] pb_ext_en,
   output logic      [7:0] pa_in,
   output logic      [6:0] pb_in
);

   // an open pin without pull-up toggles every cycle so a stale read never passes by luck
   logic tick_r = 1'b0;

   always @(posedge clk) begin
      tick_r <= ~tick_r;
   end

   // the device's own driver wins; a pulled-up open pin reads high
   assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_ext_en & pa_ext)
                | (~pa_oe & ~pa_ext_en & (pa_pullup | {8{tick_r}}));
   assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext_en & pb_ext)
                | (~pb_oe & ~pb_ext_en & (pb_pullup | {7{tick_r}}));

endmodule : tpg_pins

//--- dv/tpg_top_bench.sv
`timescale 1ns/1ps

module tpg_top_bench;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic       mclk, reset_n, ce, mem_wr, mem_rd, core_sleep, wake_req;
   logic [7:0] mem_addr, mem_wdata, mem_rdata, pa_in, pa_out, pa_oe, pa_pullup;
   logic [7:0] pa_allow, pa_sel, pa_ext, pa_ext_en;
   logic [6:0] pb_in, pb_out, pb_oe, pb_pullup, pb_allow, pb_ext, pb_ext_en;
   logic [7:0] dir_a, lvl_a, pu_a, wu_a, dir_b, lvl_b, pu_b, un_a, bit_p;
   int         fail_count, compares;

   tpg_top uut (.MCLK(mclk), .RESET_N(reset_n), .CE(ce), .MEM_ADDR(mem_addr),
      .MEM_WR(mem_wr), .MEM_RD(mem_rd), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
      .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe), .PA_PULLUP(pa_pullup),
      .PA_PU_ALLOW(pa_allow), .PA_GPIO_SEL(pa_sel), .PB_IN(pb_in), .PB_OUT(pb_out),
      .PB_OE(pb_oe), .PB_PULLUP(pb_pullup), .PB_PU_ALLOW(pb_allow),
      .CORE_SLEEP(core_sleep), .WAKE_REQ(wake_req));

   tpg_pins board (.clk(mclk), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pullup),
      .pa_ext(pa_ext), .pa_ext_en(pa_ext_en), .pb_out(pb_out), .pb_oe(pb_oe),
      .pb_pullup(pb_pullup), .pb_ext(pb_ext), .pb_ext_en(pb_ext_en), .pa_in(pa_in),
      .pb_in(pb_in));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic print_verdict;
      if (fail_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic cyc(int n);
      repeat (n) @(posedge mclk);
   endtask : cyc

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge mclk);
      mem_addr  <= a;
      mem_wdata <= d;
      mem_wr    <= 1'b1;
      @(posedge mclk);
      mem_wr    <= 1'b0;
   endtask : wr

   // read data is registered at the take edge, so it is sampled one edge later
   task automatic rdc(string what, logic [7:0] a, logic [7:0] exp, logic [7:0] m);
      @(posedge mclk);
      mem_addr <= a;
      mem_rd   <= 1'b1;
      @(posedge mclk);
      mem_rd   <= 1'b0;
      @(posedge mclk);
      check(what, mem_rdata & m, exp & m);
   endtask : rdc

   // input bits show the pin, output bits the latch; open unpulled pins are masked
   function automatic logic [7:0] lvl_exp(logic [7:0] d, l, e, en);
      return (~d & l) | (d & en & e) | (d & ~en);
   endfunction : lvl_exp

   task automatic wake_case(logic sl, logic [7:0] wu, dr, sel, fall);
      int n;
      int at;
      n  = 0;
      at = 0;
      wr(tpg_pkg::OFS_FIRST_WAKE, wu);
      wr(tpg_pkg::OFS_FIRST_DIRECTION, dr);
      pa_ext     <= 8'hFF;
      pa_ext_en  <= 8'hFF;
      pa_sel     <= sel;
      core_sleep <= sl;
      cyc(6);
      pa_ext <= ~fall;
      // sample between edges so the pulse is seen settled; at counts rising edges
      for (int k = 1; k <= 8; k++) begin
         @(negedge mclk);
         if (wake_req === 1'b1) begin
            n++;
            at = k - 1;
         end
      end
      check("wake pulses", 8'(n), {7'h00, sl & (|(fall & wu & dr & sel))});
      // meta, sync, then the pulse flop: three edges from pin to request
      if (n == 1) check("wake delay", 8'(at), 8'h03);
   endtask : wake_case

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {reset_n, ce, mem_wr, mem_rd, core_sleep} = 5'b01000;
      {mem_addr, mem_wdata, pa_allow, pa_sel} = 32'h0000_FFFF;
      {pa_ext, pa_ext_en} = 16'hA5FF;
      {pb_ext, pb_ext_en, pb_allow} = {7'h2A, 7'h7F, 7'h7F};
      fail_count = 0;
      compares   = 0;
      void'($urandom(46093));
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      check("first out", pa_out, tpg_pkg::RST_FIRST_LEVEL);
      check("first oe", pa_oe, 8'h00);
      check("first pullup", pa_pullup, 8'h00);
      check("second oe", {1'b0, pb_oe}, 8'h00);
      check("wake idle", {7'h00, wake_req}, 8'h00);
      rdc("first level", tpg_pkg::OFS_FIRST_LEVEL, 8'hA5, 8'hFF);
      rdc("second level", tpg_pkg::OFS_SECOND_LEVEL, 8'h2A, 8'hFF);
      rdc("first pullup", tpg_pkg::OFS_FIRST_PULLUP, 8'h00, 8'hFF);
      rdc("first wake", tpg_pkg::OFS_FIRST_WAKE, 8'h00, 8'hFF);
      rdc("second pullup", tpg_pkg::OFS_SECOND_PULLUP, 8'h00, 8'hFF);
      // software parks the unbonded pins as outputs
      wr(tpg_pkg::OFS_FIRST_DIRECTION, 8'h7F);
      wr(tpg_pkg::OFS_SECOND_DIRECTION, 8'hEF);
      cyc(2);
      check("first oe", pa_oe, 8'h80);
      check("second oe", {1'b0, pb_oe}, 8'h10);
      rdc("second dir", tpg_pkg::OFS_SECOND_DIRECTION, 8'h6F, 8'hFF);
      for (int i = 0; i < 24; i++) begin
         {dir_a, lvl_a, pu_a, wu_a} = $urandom;
         {dir_b, lvl_b, pu_b, un_a} = $urandom;
         if (i == 0) dir_a = 8'h00;
         if (i == 1) dir_a = 8'hFF;
         un_a = 8'($urandom_range(255, 7));
         {pa_allow, pa_ext, pa_ext_en} <= 24'($urandom);
         {pb_allow, pb_ext, pb_ext_en} <= 21'($urandom);
         wr(tpg_pkg::OFS_FIRST_LEVEL, lvl_a);
         wr(tpg_pkg::OFS_FIRST_DIRECTION, dir_a);
         wr(tpg_pkg::OFS_FIRST_PULLUP, pu_a);
         wr(tpg_pkg::OFS_FIRST_WAKE, wu_a);
         wr(tpg_pkg::OFS_SECOND_LEVEL, lvl_b);
         wr(tpg_pkg::OFS_SECOND_DIRECTION, dir_b);
         wr(tpg_pkg::OFS_SECOND_PULLUP, pu_b);
         wr(un_a, 8'hFF);
         cyc(2);
         check("first out", pa_out, lvl_a);
         check("first oe", pa_oe, ~dir_a);
         check("first pullup", pa_pullup, pu_a & pa_allow);
         check("second out", {1'b0, pb_out}, lvl_b & 8'h7F);
         check("second oe", {1'b0, pb_oe}, ~dir_b & 8'h7F);
         check("second pullup", {1'b0, pb_pullup}, pu_b & {1'b0, pb_allow});
         rdc("first dir", tpg_pkg::OFS_FIRST_DIRECTION, dir_a, 8'hFF);
         rdc("first pullup", tpg_pkg::OFS_FIRST_PULLUP, pu_a, 8'hFF);
         rdc("first wake", tpg_pkg::OFS_FIRST_WAKE, wu_a, 8'hFF);
         rdc("second dir", tpg_pkg::OFS_SECOND_DIRECTION, dir_b & 8'h7F, 8'hFF);
         rdc("second pullup", tpg_pkg::OFS_SECOND_PULLUP, pu_b & 8'h7F, 8'hFF);
         rdc("unmapped", un_a, 8'h00, 8'hFF);
         rdc("first level", tpg_pkg::OFS_FIRST_LEVEL, lvl_exp(dir_a, lvl_a, pa_ext, pa_ext_en),
             ~dir_a | pa_ext_en | (pu_a & pa_allow));
         rdc("second level", tpg_pkg::OFS_SECOND_LEVEL,
             lvl_exp({1'b0, dir_b[6:0]}, {1'b0, lvl_b[6:0]}, {1'b0, pb_ext}, {1'b0, pb_ext_en}),
             {1'b1, ~dir_b[6:0] | pb_ext_en | (pu_b[6:0] & pb_allow)});
         check("first out", pa_out, lvl_a);
      end
      // a frozen block ignores a write, so the latch must hold
      ce <= 1'b0;
      wr(tpg_pkg::OFS_FIRST_LEVEL, ~lvl_a);
      ce <= 1'b1;
      cyc(2);
      check("first out", pa_out, lvl_a);
      wr(tpg_pkg::OFS_FIRST_LEVEL, 8'hFF);
      for (int c = 0; c < 16; c++) begin
         bit_p = 8'h01 << $urandom_range(6);
         wake_case(c[0], c[1] ? bit_p : ~bit_p, c[2] ? 8'hFF : ~bit_p,
                   c[3] ? 8'hFF : ~bit_p, bit_p);
      end
      wake_case(1'b1, 8'hFF, 8'hFF, 8'hFF, 8'h41);
      print_verdict();
   end

   initial begin
      #400000;
      fail_count++;
      print_verdict();
   end

endmodule : tpg_top_bench
